// ### adc_cfg_pkg.sv
package adc_cfg_pkg;

   // ==========================================================
   // frame layout (zero-based bit index in the 16-bit word)
   localparam int WORD_W = 16;
   localparam int RISE_MARK = 15;
   localparam int WRITE_BIT = 15;
   localparam int SEL_HI = 14;
   localparam int SEL_LO = 13;
   localparam int ADDR_HI = 12;
   localparam int ADDR_LO = 10;
   localparam int PM_HI = 7;
   localparam int PM_LO = 6;
   localparam int STEP_A = 3;
   localparam int STEP_B = 2;
   localparam int FIELD_HI = 12;
   localparam int FIELD_LO = 5;
   localparam int NUM_CH = 8;

   // ==========================================================
   // register select codes
   localparam logic [1:0] SEL_CONTROL = 2'h0;
   localparam logic [1:0] SEL_RANGE_LO = 2'h1;
   localparam logic [1:0] SEL_RANGE_HI = 2'h2;
   localparam logic [1:0] SEL_SEQUENCE = 2'h3;

   // ==========================================================
   // power and step codes
   localparam logic [1:0] PM_NORMAL = 2'h0;
   localparam logic [1:0] PM_AUTOSTANDBY = 2'h1;
   localparam logic [1:0] PM_AUTOSHUTDOWN = 2'h2;
   localparam logic [1:0] PM_FULL_OFF = 2'h3;
   localparam logic [1:0] STEP_SINGLE = 2'h0;
   localparam logic [1:0] STEP_PROGRAMMED = 2'h1;
   localparam logic [1:0] STEP_CONSECUTIVE = 2'h2;
   localparam logic [1:0] STEP_SINGLE_ALT = 2'h3;

   // ==========================================================
   // reset values
   localparam logic [7:0] RANGE_RESET = 8'h00;
   localparam logic [7:0] SEQ_RESET = 8'h00;
   localparam logic [2:0] CHAN_ZERO = 3'h0;

   typedef enum logic [1:0] {
      RANGE_BIP_10 = 2'h0,
      RANGE_BIP_5 = 2'h1,
      RANGE_BIP_2P5 = 2'h2,
      RANGE_UNI_10 = 2'h3
   } range_t;

   typedef struct packed {
      logic [2:0] channel;
      range_t range;
   } conv_req_t;

   typedef struct packed {
      logic [2:0] chan_addr;
      logic [1:0] power_sel;
      logic [1:0] step_ctl;
   } ctrl_t;

   localparam ctrl_t CTRL_RESET = '{chan_addr: 3'h0, power_sel: 2'h0, step_ctl: 2'h0};

   typedef enum logic [4:0] {
      PS_ON = 5'h01,
      PS_AWAKE = 5'h02,
      PS_STANDBY = 5'h04,
      PS_SHUTDOWN = 5'h08,
      PS_FULL_OFF = 5'h10
   } power_state_t;

endpackage

// ### serial_frame_rx.sv
`timescale 1ns/1ps
module serial_frame_rx #(
   parameter int WORD_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   // frame events
   output logic frame_start,
   output logic rise_mark,
   output logic frame_done,
   output logic [WORD_W-1:0] word
);

   // ==========================================================
   // synchronisers
   logic [2:0] sclk_s;
   logic [2:0] cs_s;
   logic [1:0] din_s;
   logic [4:0] fall_cnt;
   logic [4:0] rise_cnt;
   logic sclk_fall;
   logic sclk_rise;
   logic cs_fall;
   logic active;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclk_s <= 3'h7;
         cs_s <= 3'h7;
         din_s <= 2'h0;
      end else begin
         sclk_s <= {sclk_s[1:0], sclk};
         cs_s <= {cs_s[1:0], cs_n};
         din_s <= {din_s[0], din};
      end
   end

   assign sclk_fall = sclk_s[2] & ~sclk_s[1];
   assign sclk_rise = ~sclk_s[2] & sclk_s[1];
   assign cs_fall = cs_s[2] & ~cs_s[1];
   assign active = ~cs_s[1] & ~cs_s[2];

   // ==========================================================
   // shift and edge counting
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         word <= '0;
         fall_cnt <= 5'h0;
         rise_cnt <= 5'h0;
         frame_start <= 1'b0;
         rise_mark <= 1'b0;
         frame_done <= 1'b0;
      end else begin
         frame_start <= cs_fall;
         rise_mark <= 1'b0;
         frame_done <= 1'b0;
         if (cs_fall) begin
            fall_cnt <= 5'h0;
            rise_cnt <= 5'h0;
         end else if (active) begin
            if (sclk_fall && fall_cnt < 5'(WORD_W)) begin
               word <= {word[WORD_W-2:0], din_s[1]};
               fall_cnt <= fall_cnt + 5'h1;
               frame_done <= (fall_cnt == 5'(WORD_W - 1));
            end
            if (sclk_rise && rise_cnt < 5'(WORD_W)) begin
               rise_cnt <= rise_cnt + 5'h1;
               rise_mark <= (rise_cnt == 5'(adc_cfg_pkg::RISE_MARK - 1));
            end
         end
      end
   end

endmodule

// ### channel_stepper.sv
`timescale 1ns/1ps
module channel_stepper #(
   parameter int NUM_CH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // control
   input wire logic restart,
   input wire logic advance,
   input wire logic [1:0] step_ctl,
   input wire logic [NUM_CH-1:0] seq_mask,
   input wire logic [2:0] chan_addr,
   // selection
   output logic [2:0] channel
);

   logic [2:0] cur;

   // lowest enabled channel above from, wrapping
   function automatic logic [2:0] next_on(input logic [NUM_CH-1:0] m, input logic [2:0] from);
      logic [2:0] r;
      logic hit;
      r = adc_cfg_pkg::CHAN_ZERO;
      hit = 1'b0;
      for (int i = 1; i <= NUM_CH; i++) begin
         if (!hit && m[3'(from + 3'(i))]) begin
            r = 3'(from + 3'(i));
            hit = 1'b1;
         end
      end
      return r;
   endfunction

   always_comb begin
      unique case (step_ctl)
         adc_cfg_pkg::STEP_PROGRAMMED: channel = cur;
         adc_cfg_pkg::STEP_CONSECUTIVE: channel = cur;
         adc_cfg_pkg::STEP_SINGLE: channel = chan_addr;
         adc_cfg_pkg::STEP_SINGLE_ALT: channel = chan_addr;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cur <= adc_cfg_pkg::CHAN_ZERO;
      end else if (restart) begin
         if (step_ctl == adc_cfg_pkg::STEP_PROGRAMMED) begin
            cur <= next_on(seq_mask, 3'(NUM_CH - 1));
         end else begin
            cur <= adc_cfg_pkg::CHAN_ZERO;
         end
      end else if (advance) begin
         if (step_ctl == adc_cfg_pkg::STEP_PROGRAMMED) begin
            cur <= next_on(seq_mask, cur);
         end else if (step_ctl == adc_cfg_pkg::STEP_CONSECUTIVE) begin
            cur <= (cur >= chan_addr) ? adc_cfg_pkg::CHAN_ZERO : cur + 3'h1;
         end
      end
   end

endmodule

// ### adc_power_sequencer_range_cfg.sv
`timescale 1ns/1ps
module adc_power_sequencer_range_cfg #(
   parameter int NUM_CH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   // power controls
   output logic core_power_on,
   output logic ref_power_on,
   output logic [1:0] power_mode,
   // conversion request
   output logic conv_start,
   output adc_cfg_pkg::conv_req_t conv_req,
   output logic [1:0] step_mode
);

   // ==========================================================
   // frame receiver
   logic frame_start;
   logic rise_mark;
   logic frame_done;
   logic [adc_cfg_pkg::WORD_W-1:0] rx_word;
   logic [adc_cfg_pkg::WORD_W-1:0] early_word;

   serial_frame_rx #(
      .WORD_W(adc_cfg_pkg::WORD_W)
   ) u_rx (
      .clk(clk),
      .rstn(rstn),
      .sclk(sclk),
      .cs_n(cs_n),
      .din(din),
      .frame_start(frame_start),
      .rise_mark(rise_mark),
      .frame_done(frame_done),
      .word(rx_word)
   );

   // at the 15th rise only fifteen bits are in; realign to full word positions
   assign early_word = {rx_word[adc_cfg_pkg::WORD_W-2:0], 1'b0};

   // ==========================================================
   // field helpers
   function automatic logic is_write(input logic [adc_cfg_pkg::WORD_W-1:0] w);
      return w[adc_cfg_pkg::WRITE_BIT];
   endfunction

   function automatic logic [1:0] sel_of(input logic [adc_cfg_pkg::WORD_W-1:0] w);
      return {w[adc_cfg_pkg::SEL_HI], w[adc_cfg_pkg::SEL_LO]};
   endfunction

   function automatic logic [1:0] pm_of(input logic [adc_cfg_pkg::WORD_W-1:0] w);
      return {w[adc_cfg_pkg::PM_HI], w[adc_cfg_pkg::PM_LO]};
   endfunction

   function automatic logic [7:0] field_of(input logic [adc_cfg_pkg::WORD_W-1:0] w);
      return w[adc_cfg_pkg::FIELD_HI:adc_cfg_pkg::FIELD_LO];
   endfunction

   function automatic logic ctrl_write(input logic [adc_cfg_pkg::WORD_W-1:0] w);
      return is_write(w) && (sel_of(w) == adc_cfg_pkg::SEL_CONTROL);
   endfunction

   // ==========================================================
   // registers
   adc_cfg_pkg::ctrl_t ctrl_reg;
   logic [7:0] seq_reg;
   logic [7:0] range_lo_reg;
   logic [7:0] range_hi_reg;
   logic [NUM_CH-1:0] seq_mask;
   logic restart_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= adc_cfg_pkg::CTRL_RESET;
      end else if (frame_done && ctrl_write(rx_word)) begin
         ctrl_reg.chan_addr <= rx_word[adc_cfg_pkg::ADDR_HI:adc_cfg_pkg::ADDR_LO];
         ctrl_reg.power_sel <= pm_of(rx_word);
         ctrl_reg.step_ctl <= {rx_word[adc_cfg_pkg::STEP_A],
                               rx_word[adc_cfg_pkg::STEP_B]};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         seq_reg <= adc_cfg_pkg::SEQ_RESET;
      end else if (frame_done && is_write(rx_word)
                   && sel_of(rx_word) == adc_cfg_pkg::SEL_SEQUENCE) begin
         seq_reg <= field_of(rx_word);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         range_lo_reg <= adc_cfg_pkg::RANGE_RESET;
         range_hi_reg <= adc_cfg_pkg::RANGE_RESET;
      end else if (frame_done && is_write(rx_word)) begin
         if (sel_of(rx_word) == adc_cfg_pkg::SEL_RANGE_LO) begin
            range_lo_reg <= field_of(rx_word);
         end
         if (sel_of(rx_word) == adc_cfg_pkg::SEL_RANGE_HI) begin
            range_hi_reg <= field_of(rx_word);
         end
      end
   end

   // a control write restarts the stepper once the new fields are stored
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         restart_reg <= 1'b0;
      end else begin
         restart_reg <= frame_done && ctrl_write(rx_word);
      end
   end

   // first channel sits in the top bit of the stored field
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         seq_mask[i] = seq_reg[NUM_CH-1-i];
      end
   end

   // ==========================================================
   // range lookup
   function automatic adc_cfg_pkg::range_t range_of(input logic [2:0] ch,
                                                    input logic [7:0] lo,
                                                    input logic [7:0] hi);
      logic [7:0] r;
      logic [1:0] pos;
      r = ch[2] ? hi : lo;
      pos = 2'(3 - ch[1:0]);
      return adc_cfg_pkg::range_t'({r[{pos, 1'b1}], r[{pos, 1'b0}]});
   endfunction

   // ==========================================================
   // channel stepping
   logic [2:0] next_chan;
   logic take_conv;

   channel_stepper #(
      .NUM_CH(NUM_CH)
   ) u_step (
      .clk(clk),
      .rstn(rstn),
      .restart(restart_reg),
      .advance(take_conv),
      .step_ctl(ctrl_reg.step_ctl),
      .seq_mask(seq_mask),
      .chan_addr(ctrl_reg.chan_addr),
      .channel(next_chan)
   );

   // ==========================================================
   // power state
   adc_cfg_pkg::power_state_t pstate;
   logic [1:0] pm_eff;

   function automatic adc_cfg_pkg::power_state_t down_state(input logic [1:0] pm);
      adc_cfg_pkg::power_state_t s;
      unique case (pm)
         adc_cfg_pkg::PM_FULL_OFF: s = adc_cfg_pkg::PS_FULL_OFF;
         adc_cfg_pkg::PM_AUTOSHUTDOWN: s = adc_cfg_pkg::PS_SHUTDOWN;
         adc_cfg_pkg::PM_AUTOSTANDBY: s = adc_cfg_pkg::PS_STANDBY;
         adc_cfg_pkg::PM_NORMAL: s = adc_cfg_pkg::PS_ON;
      endcase
      return s;
   endfunction

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pm_eff <= adc_cfg_pkg::PM_NORMAL;
      end else if (rise_mark && ctrl_write(early_word)) begin
         pm_eff <= pm_of(early_word);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pstate <= adc_cfg_pkg::PS_ON;
      end else begin
         unique case (pstate)
            adc_cfg_pkg::PS_ON: begin
               if (rise_mark && ctrl_write(early_word)) begin
                  pstate <= down_state(pm_of(early_word));
               end
            end
            adc_cfg_pkg::PS_AWAKE: begin
               if (rise_mark && ctrl_write(early_word)) begin
                  pstate <= down_state(pm_of(early_word));
               end else if (rise_mark) begin
                  pstate <= down_state(pm_eff);
               end
            end
            adc_cfg_pkg::PS_STANDBY, adc_cfg_pkg::PS_SHUTDOWN: begin
               if (frame_start) begin
                  pstate <= adc_cfg_pkg::PS_AWAKE;
               end
            end
            adc_cfg_pkg::PS_FULL_OFF: begin
               if (rise_mark && ctrl_write(early_word)) begin
                  pstate <= down_state(pm_of(early_word));
               end
            end
            default: pstate <= adc_cfg_pkg::PS_ON;
         endcase
      end
   end

   // ==========================================================
   // power outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         core_power_on <= 1'b1;
         ref_power_on <= 1'b1;
         power_mode <= adc_cfg_pkg::PM_NORMAL;
      end else begin
         core_power_on <= (pstate == adc_cfg_pkg::PS_ON)
                          || (pstate == adc_cfg_pkg::PS_AWAKE);
         ref_power_on <= (pstate == adc_cfg_pkg::PS_ON) || (pstate == adc_cfg_pkg::PS_AWAKE)
                         || (pstate == adc_cfg_pkg::PS_STANDBY);
         power_mode <= pm_eff;
      end
   end

   // ==========================================================
   // conversion request
   assign take_conv = frame_start && (pstate != adc_cfg_pkg::PS_FULL_OFF);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         conv_start <= 1'b0;
         conv_req <= '{channel: adc_cfg_pkg::CHAN_ZERO, range: adc_cfg_pkg::RANGE_BIP_10};
         step_mode <= adc_cfg_pkg::STEP_SINGLE;
      end else begin
         conv_start <= take_conv;
         step_mode <= ctrl_reg.step_ctl;
         if (take_conv) begin
            conv_req.channel <= next_chan;
            conv_req.range <= range_of(next_chan, range_lo_reg, range_hi_reg);
         end
      end
   end

endmodule

// ### adc_cfg_asserts.sv
`timescale 1ns/1ps
module adc_cfg_checker #(
   parameter int NUM_CH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   // watched outputs
   input wire logic core_power_on,
   input wire logic ref_power_on,
   input wire logic [1:0] power_mode,
   input wire logic conv_start,
   input wire adc_cfg_pkg::conv_req_t conv_req,
   input wire logic [1:0] step_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic sclk_q;
   logic cs_q;
   logic [4:0] fall_cnt;
   logic [3:0] high_cnt;
   // ==========================================================
   // frame bookkeeping
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclk_q <= 1'b1;
         cs_q <= 1'b1;
      end else begin
         sclk_q <= sclk;
         cs_q <= cs_n;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) fall_cnt <= 5'h0;
      else if (cs_q && !cs_n) fall_cnt <= 5'h0;
      else if (!cs_n && sclk_q && !sclk && fall_cnt != 5'h1f) fall_cnt <= fall_cnt + 5'h1;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) high_cnt <= 4'h0;
      else if (!cs_n) high_cnt <= 4'h0;
      else if (high_cnt != 4'hf) high_cnt <= high_cnt + 4'h1;
   end
   // ==========================================================
   // power decode
   a_full_off_dark: assert property (power_mode == 2'h3 && $stable(power_mode) |->
      !core_power_on && !ref_power_on) else $error("full off still powered");
   a_normal_all_on: assert property (power_mode == 2'h0 && $stable(power_mode) |->
      core_power_on && ref_power_on) else $error("normal mode not powered");
   a_shutdown_idle_dark: assert property (power_mode == 2'h2 && high_cnt > 4'h7 |->
      !core_power_on && !ref_power_on) else $error("autoshutdown powered between frames");
   a_standby_ref_kept: assert property (power_mode == 2'h1 && high_cnt > 4'h7 |->
      !core_power_on && ref_power_on) else $error("autostandby power wrong");
   a_power_at_mark: assert property ($changed(power_mode) |->
      fall_cnt inside {5'hf, 5'h10}) else $error("power change away from 15th edge");
   // ==========================================================
   // conversion and registers
   a_off_no_start: assert property (conv_start |-> power_mode != 2'h3)
      else $error("conversion started in full off");
   a_req_with_start: assert property ($changed(conv_req) |-> conv_start)
      else $error("conversion request changed without start");
   a_step_frame_end: assert property ($changed(step_mode) |-> fall_cnt == 5'h10)
      else $error("step code changed before frame end");
   c_start: cover property (conv_start);
   c_full_off: cover property (power_mode == 2'h3);
   c_programmed: cover property (step_mode == 2'h1 && conv_start);
endmodule
bind adc_power_sequencer_range_cfg adc_cfg_checker #(.NUM_CH(NUM_CH)) chk (.clk(clk),
   .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din), .core_power_on(core_power_on),
   .ref_power_on(ref_power_on), .power_mode(power_mode), .conv_start(conv_start),
   .conv_req(conv_req), .step_mode(step_mode));

// ### host_model.sv
`timescale 1ns/1ps
module host_model (
   // serial pins
   output logic sclk,
   output logic cs_n,
   output logic din
);
   // ==========================================================
   // idle pins
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b0;
   end
   // ==========================================================
   // one frame, msb first, cut short after n bits
   task automatic send(input logic [15:0] w, input int n);
      cs_n = 1'b0;
      #62.5;
      for (int i = 0; i < n; i++) begin
         din = w[15-i];
         #31.25 sclk = 1'b0;
         #62.5 sclk = 1'b1;
         #31.25;
      end
      #62.5 cs_n = 1'b1;
      din = ~din;
      #300;
   endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
   // ==========================================================
   // signals
   logic clk;
   logic rstn;
   logic sclk;
   logic cs_n;
   logic din;
   logic core_power_on;
   logic ref_power_on;
   logic [1:0] power_mode;
   logic conv_start;
   adc_cfg_pkg::conv_req_t conv_req;
   adc_cfg_pkg::conv_req_t last_req = '0;
   logic [1:0] step_mode;
   int bad_count = 0;
   int checks_done = 0;
   int starts = 0;
   int cycles = 0;
   int seen;
   logic [1:0] exp_rng [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0};
   logic [1:0] steps [3] = '{2'h1, 2'h2, 2'h3};
   int addrs [3] = '{4, 2, 4};
   int order [3][6] = '{'{1, 3, 6, 1, 3, 6}, '{0, 1, 2, 0, 1, 2}, '{4, 4, 4, 4, 4, 4}};
   host_model host (.sclk(sclk), .cs_n(cs_n), .din(din));
   adc_power_sequencer_range_cfg #(.NUM_CH(8)) uut (.clk(clk), .rstn(rstn), .sclk(sclk),
      .cs_n(cs_n), .din(din), .core_power_on(core_power_on), .ref_power_on(ref_power_on),
      .power_mode(power_mode), .conv_start(conv_start), .conv_req(conv_req),
      .step_mode(step_mode));
   // ==========================================================
   // clock, capture, timeout
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (conv_start === 1'b1) begin
         last_req <= conv_req;
         starts <= starts + 1;
      end
      if (cycles == 40000) begin
         bad_count++;
         results();
      end
   end
   // ==========================================================
   // tasks
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic ctrl(input logic [2:0] a, input logic [1:0] p, input logic [1:0] s, input int n);
      host.send({1'b1, adc_cfg_pkg::SEL_CONTROL, a, 2'h0, p, 2'h0, s, 2'h0}, n);
   endtask
   task automatic wr(input logic [1:0] sel, input logic [7:0] f);
      host.send({1'b1, sel, f, 5'h0}, 16);
   endtask
   task automatic conv(input logic [2:0] c, input logic [1:0] r);
      host.send(16'h7fff, 16);
      chk("channel", 8'(c), 8'(last_req.channel));
      chk("range", 8'(r), 8'(last_req.range));
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      rstn = 1'b0;
      repeat (4) @(posedge clk);
      #1 rstn = 1'b1;
      chk("core_on", 8'h1, 8'(core_power_on));
      chk("ref_on", 8'h1, 8'(ref_power_on));
      chk("power_mode", 8'h0, 8'(power_mode));
      chk("conv_req", 8'h0, 8'(conv_req));
      chk("step_mode", 8'h0, 8'(step_mode));
      repeat (3) @(posedge clk);
      #1 ctrl(3'h5, 2'h0, 2'h0, 16);
      conv(3'h5, 2'h0);
      wr(adc_cfg_pkg::SEL_RANGE_LO, 8'h1b);
      wr(adc_cfg_pkg::SEL_RANGE_HI, 8'he4);
      for (int c = 0; c < 8; c++) begin
         ctrl(3'(c), 2'h0, 2'h0, 16);
         conv(3'(c), exp_rng[c]);
      end
      ctrl(3'h2, 2'h1, 2'h0, 14);
      chk("power_mode", 8'h0, 8'(power_mode));
      ctrl(3'h2, 2'h1, 2'h0, 15);
      chk("power_mode", 8'h1, 8'(power_mode));
      conv(3'h7, exp_rng[7]);
      for (int p = 1; p < 4; p++) begin
         ctrl(3'h7, 2'(p), 2'h0, 16);
         chk("power_mode", 8'(p), 8'(power_mode));
         chk("core_on", 8'h0, 8'(core_power_on));
         chk("ref_on", 8'(p == 1), 8'(ref_power_on));
      end
      seen = starts;
      host.send(16'h7fff, 16);
      chk("starts", 8'(seen), 8'(starts));
      ctrl(3'h7, 2'h0, 2'h0, 16);
      chk("core_on", 8'h1, 8'(core_power_on));
      chk("ref_on", 8'h1, 8'(ref_power_on));
      wr(adc_cfg_pkg::SEL_SEQUENCE, 8'h52);
      for (int m = 0; m < 3; m++) begin
         ctrl(3'(addrs[m]), 2'h0, steps[m], 16);
         chk("step_mode", 8'(steps[m]), 8'(step_mode));
         for (int i = 0; i < 6; i++) begin
            conv(3'(order[m][i]), exp_rng[order[m][i]]);
         end
      end
      ctrl(3'h4, 2'h0, 2'h0, 16);
      wr(adc_cfg_pkg::SEL_RANGE_LO, 8'h00);
      ctrl(3'h4, 2'h0, 2'h1, 16);
      conv(3'h1, 2'h0);
      results();
   end
endmodule
